// ===== design/sdsn_pkg.sv
// ==========================================================================
// Shared constants of the serial decision switch node
package sdsn_pkg;

	// ======================================================================
	// Shape of the node
	localparam int SDSN_PORTS        = 4;
	localparam int SDSN_NIB_W        = 4;
	localparam int SDSN_EXIT_CHOICES = 2;
	localparam int SDSN_MIN_STAGES   = 3;

	// ======================================================================
	// Head nibble layout: the low bit steers this node, then is rotated away
	localparam int SDSN_ROUTE_BIT = 0;

	// ======================================================================
	// Exit buffering
	localparam int SDSN_FIFO_DEPTH   = 16;
	localparam int SDSN_READY_MARGIN = 2;

	// ======================================================================
	// Entry port state
	typedef enum logic [0:0] {
		SDSN_IN_IDLE,
		SDSN_IN_PASS
	} sdsn_in_e;

endpackage : sdsn_pkg

// ===== design/sdsn_fifo.sv
`timescale 1ns/10ps
// ==========================================================================
// Exit FIFO with registered read data
module sdsn_fifo
	import sdsn_pkg::*;
#(
	parameter int WIDTH = SDSN_NIB_W + 1,
	parameter int DEPTH = SDSN_FIFO_DEPTH,
	parameter int LW    = $clog2(SDSN_FIFO_DEPTH) + 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic             flush,
	// Fill side
	input  wire logic             s_valid,
	input  wire logic [WIDTH-1:0] s_data,
	output logic                  s_ready,
	// Drain side
	output logic                  m_valid,
	output logic      [WIDTH-1:0] m_data,
	input  wire logic             m_ready,
	// Fill level, output stage included
	output logic      [LW-1:0]    level
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH || LW != AW + 1) begin : g_bad_depth
		$error("sdsn_fifo: DEPTH must be a power of two, LW its log2 plus one");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [LW-1:0]    cnt_q;
	logic             m_valid_q;
	logic [WIDTH-1:0] m_data_q;
	logic             push;
	logic             pop;

	assign level   = cnt_q + LW'(m_valid_q);
	// Full counts the output stage too, so a stalled drain really fills it
	assign s_ready = level < LW'(DEPTH);
	assign push    = s_valid && s_ready && !flush;
	assign pop     = (cnt_q != '0) && (!m_valid_q || m_ready) && !flush;
	assign m_valid = m_valid_q;
	assign m_data  = m_data_q;

	// ======================================================================
	// Storage, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= s_data;
		end
	end

	// ======================================================================
	// Pointers and count
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end else if (flush) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + AW'(1);
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + AW'(1);
			end
			cnt_q <= cnt_q + LW'(push) - LW'(pop);
		end
	end

	// ======================================================================
	// Output register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			m_valid_q <= 1'b0;
			m_data_q  <= '0;
		end else if (flush) begin
			m_valid_q <= 1'b0;
		end else if (pop) begin
			m_valid_q <= 1'b1;
			m_data_q  <= mem_q[rd_ptr_q];
		end else if (m_ready) begin
			m_valid_q <= 1'b0;
		end
	end

endmodule : sdsn_fifo

// ===== design/sdsn_arb2.sv
`timescale 1ns/10ps
// ==========================================================================
// Two-way rotating priority arbiter for one exit
module sdsn_arb2
	import sdsn_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Requests and grant
	input  wire logic [1:0] req,
	input  wire logic       take,
	output logic            gnt_any,
	output logic            gnt_idx
);
	logic last_q;

	assign gnt_any = |req;
	// Both asking: the one that did not win last time goes first
	assign gnt_idx = (req == 2'b11) ? !last_q : req[1];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			last_q <= 1'b0;
		end else if (take && gnt_any) begin
			last_q <= gnt_idx;
		end
	end

endmodule : sdsn_arb2

// ===== design/sdsn_node.sv
`timescale 1ns/10ps
// ==========================================================================
module sdsn_node
	import sdsn_pkg::*;
#(
	parameter int PORTS      = SDSN_PORTS,
	parameter int NIB_W      = SDSN_NIB_W,
	parameter int FIFO_DEPTH = SDSN_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   rstn,
	// Entry ports, from the left
	input  wire logic [PORTS-1:0]       in_valid,
	input  wire logic [PORTS-1:0]       in_last,
	input  wire logic [PORTS*NIB_W-1:0] in_data,
	output logic      [PORTS-1:0]       in_ready,
	output logic      [PORTS-1:0]       in_reject,
	// Exit ports, toward the right
	output logic      [PORTS-1:0]       out_valid,
	output logic      [PORTS-1:0]       out_last,
	output logic      [PORTS*NIB_W-1:0] out_data,
	input  wire logic [PORTS-1:0]       out_ready,
	input  wire logic [PORTS-1:0]       out_reject
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;
	localparam int FW = NIB_W + 1;

	// ======================================================================
	// Elaboration checks
	if (PORTS != SDSN_PORTS) begin : g_bad_ports
		$error("sdsn_node: the exit mapping serves exactly four ports");
	end
	if (NIB_W < SDSN_MIN_STAGES) begin : g_bad_width
		$error("sdsn_node: a head nibble must carry a route bit per stage");
	end
	if (FIFO_DEPTH <= SDSN_READY_MARGIN) begin : g_bad_depth
		$error("sdsn_node: exit FIFO too shallow for the ready margin");
	end
	if ((1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin : g_bad_pow2
		$error("sdsn_node: exit FIFO depth must be a power of two");
	end

	// ======================================================================
	// Entry side state
	sdsn_in_e         in_st_q [PORTS];
	sdsn_in_e         in_st_d [PORTS];
	logic [PORTS-1:0] in_rt_q;
	logic [PORTS-1:0] in_ready_q;
	logic [PORTS-1:0] in_reject_q;
	logic [PORTS-1:0] hreq;
	logic [PORTS-1:0] beat;
	logic [PORTS-1:0] won;
	logic [PORTS-1:0] killed;
	logic [1:0]       tgt [PORTS];

	// ======================================================================
	// Exit side state
	logic [PORTS-1:0] ex_busy_q;
	logic [PORTS-1:0] ex_own_q;
	logic [PORTS-1:0] ex_room;
	logic [PORTS-1:0] ex_cancel;
	logic [PORTS-1:0] ex_hit  [PORTS];
	logic [PORTS-1:0] ex_kill [PORTS];
	logic [PORTS-1:0] f_valid;
	logic [FW-1:0]    f_data  [PORTS];
	logic [PORTS-1:0] f_s_ready;
	logic [LW-1:0]    f_level [PORTS];

	assign in_ready  = in_ready_q;
	assign in_reject = in_reject_q;

	// ======================================================================
	// Per entry port: route pick and message tracking
	for (genvar i = 0; i < PORTS; i++) begin : g_in
		localparam logic [1:0] IB = 2'(i);
		logic head_bit;
		logic rt;
		logic lost;
		logic retreat;

		// ==================================================================
		// Route pick
		assign head_bit = in_data[i*NIB_W + SDSN_ROUTE_BIT];
		// Idle takes the route from the head itself, later from the latch
		assign rt       = (in_st_q[i] == SDSN_IN_IDLE) ? head_bit : in_rt_q[i];
		// Exit sits to the right of every entry, so traffic only turns one way
		assign tgt[i]   = {rt, IB[1]};
		assign beat[i]  = in_valid[i] && in_ready_q[i];
		assign hreq[i]  = beat[i] && (in_st_q[i] == SDSN_IN_IDLE);

		// ==================================================================
		// Next entry state
		always_comb begin
			in_st_d[i] = in_st_q[i];
			case (in_st_q[i])
				SDSN_IN_IDLE: begin
					if (hreq[i] && won[i] && !in_last[i]) begin
						in_st_d[i] = SDSN_IN_PASS;
					end
				end
				SDSN_IN_PASS: begin
					if (killed[i]) begin
						in_st_d[i] = SDSN_IN_IDLE;
					end else if (beat[i] && in_last[i]) begin
						in_st_d[i] = SDSN_IN_IDLE;
					end
				end
				default: begin
					in_st_d[i] = SDSN_IN_IDLE;
				end
			endcase
		end

		// ==================================================================
		// Entry state
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				in_st_q[i] <= SDSN_IN_IDLE;
			end else begin
				in_st_q[i] <= in_st_d[i];
			end
		end

		// ==================================================================
		// Route latched with the head, so body nibbles need no route bit
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				in_rt_q[i] <= 1'b0;
			end else if (hreq[i]) begin
				in_rt_q[i] <= head_bit;
			end
		end

		// ==================================================================
		// Loser of a head, or a message cancelled downstream, retreats
		assign lost    = hreq[i] && !won[i];
		assign retreat = killed[i];
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				in_reject_q[i] <= 1'b0;
			end else begin
				in_reject_q[i] <= lost || retreat;
			end
		end

		// ==================================================================
		// Ready lags a cycle, so the exit keeps a margin of free words
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				in_ready_q[i] <= 1'b0;
			end else if (in_st_d[i] == SDSN_IN_PASS) begin
				in_ready_q[i] <= ex_room[tgt[i]];
			end else begin
				in_ready_q[i] <= 1'b1;
			end
		end
	end

	// ======================================================================
	// Gather grants and cancels back onto the entries
	always_comb begin
		won    = '0;
		killed = '0;
		for (int e = 0; e < PORTS; e++) begin
			won    = won | ex_hit[e];
			killed = killed | ex_kill[e];
		end
	end

	// ======================================================================
	// Per exit port: arbitration, ownership and buffering
	for (genvar e = 0; e < PORTS; e++) begin : g_ex
		localparam logic [1:0] EI  = 2'(e);
		localparam logic [1:0] ELO = {EI[0], 1'b0};
		localparam logic [1:0] EHI = {EI[0], 1'b1};
		logic [1:0] req;
		logic       gnt_any;
		logic       gnt_idx;
		logic       free;
		logic       win;
		logic       own;
		logic [1:0] own_i;
		logic       own_pass;
		logic       done;
		logic       body_push;

		// Only the two entries sharing this exit's row bit can ask for it
		assign req[0] = hreq[ELO] && (tgt[ELO] == EI);
		assign req[1] = hreq[EHI] && (tgt[EHI] == EI);
		assign free   = !ex_busy_q[e] && f_s_ready[e];
		assign win    = gnt_any && free;

		// ==================================================================
		// Rotating tie break
		sdsn_arb2 u_arb (
			.clk     (sys_clk),
			.rstn    (rstn),
			.req     (req),
			.take    (free),
			.gnt_any (gnt_any),
			.gnt_idx (gnt_idx)
		);

		// ==================================================================
		// Owner of the exit
		assign own      = ex_busy_q[e] ? ex_own_q[e] : gnt_idx;
		assign own_i    = {EI[0], own};
		// Tail still at entry: only then can the path be retraced
		assign own_pass = ex_busy_q[e] && (in_st_q[own_i] == SDSN_IN_PASS) &&
			(tgt[own_i] == EI);
		assign ex_cancel[e] = own_pass && out_reject[e];
		assign done     = out_valid[e] && out_ready[e] && out_last[e];
		assign ex_room[e] = f_level[e] < LW'(FIFO_DEPTH - SDSN_READY_MARGIN);

		always_comb begin
			ex_hit[e]  = '0;
			ex_kill[e] = '0;
			if (win) begin
				ex_hit[e][own_i] = 1'b1;
			end
			if (ex_cancel[e]) begin
				ex_kill[e][own_i] = 1'b1;
			end
		end

		// ==================================================================
		// Body nibbles follow the owner only while its path still stands
		assign body_push = own_pass && beat[own_i] && !ex_cancel[e];

		// Head is rotated so the next node finds its own route bit low
		always_comb begin
			f_valid[e] = 1'b0;
			f_data[e]  = {in_last[own_i], in_data[own_i*NIB_W +: NIB_W]};
			if (win) begin
				f_valid[e] = 1'b1;
				f_data[e]  = {in_last[own_i], in_data[own_i*NIB_W + SDSN_ROUTE_BIT],
					in_data[own_i*NIB_W + 1 +: NIB_W-1]};
			end else if (body_push) begin
				f_valid[e] = 1'b1;
			end
		end

		// ==================================================================
		// Exit is held only until the tail has left or the message retreated
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				ex_busy_q[e] <= 1'b0;
			end else if (win) begin
				ex_busy_q[e] <= 1'b1;
			end else if (ex_cancel[e] || done) begin
				ex_busy_q[e] <= 1'b0;
			end
		end

		// ==================================================================
		// Owner remembered for the body nibbles and for a retreat
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				ex_own_q[e] <= 1'b0;
			end else if (win) begin
				ex_own_q[e] <= gnt_idx;
			end
		end

		// ==================================================================
		// Sixteen nibbles of slack only, not room for a whole long message
		sdsn_fifo #(
			.WIDTH (FW),
			.DEPTH (FIFO_DEPTH),
			.LW    (LW)
		) u_fifo (
			.clk     (sys_clk),
			.rstn    (rstn),
			.flush   (ex_cancel[e]),
			.s_valid (f_valid[e]),
			.s_data  (f_data[e]),
			.s_ready (f_s_ready[e]),
			.m_valid (out_valid[e]),
			.m_data  ({out_last[e], out_data[e*NIB_W +: NIB_W]}),
			.m_ready (out_ready[e]),
			.level   (f_level[e])
		);
	end

endmodule : sdsn_node

// ===== tb/sdsn_node_monitor.sv
`timescale 1ns/10ps
// ==========================================================================
// Port-level checker of the switch node
module sdsn_node_monitor
	import sdsn_pkg::*;
#(
	parameter int PORTS      = SDSN_PORTS,
	parameter int NIB_W      = SDSN_NIB_W,
	parameter int FIFO_DEPTH = SDSN_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic                   sys_clk,
	input wire logic                   rstn,
	// Entry side
	input wire logic [PORTS-1:0]       in_valid,
	input wire logic [PORTS-1:0]       in_last,
	input wire logic [PORTS*NIB_W-1:0] in_data,
	input wire logic [PORTS-1:0]       in_ready,
	input wire logic [PORTS-1:0]       in_reject,
	// Exit side
	input wire logic [PORTS-1:0]       out_valid,
	input wire logic [PORTS-1:0]       out_last,
	input wire logic [PORTS*NIB_W-1:0] out_data,
	input wire logic [PORTS-1:0]       out_ready,
	input wire logic [PORTS-1:0]       out_reject
);
	// ======================================================================
	// Message tracking per entry, seen only from the handshakes and rejects
	logic [PORTS-1:0] busy_q;
	wire  [PORTS-1:0] take = in_valid & in_ready;
	wire  [PORTS-1:0] hd   = take & ~busy_q;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) busy_q <= '0;
		else busy_q <= (busy_q | (take & ~in_last)) & ~(take & in_last) & ~in_reject;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// ======================================================================
	// Assertions
	sequence s_tie(int a, int b);
		hd[a] && hd[b] && in_data[NIB_W*a] == in_data[NIB_W*b];
	endsequence
	property p_one_loses(int a, int b);
		s_tie(a, b) |=> in_reject[a] || in_reject[b];
	endproperty

	AST_RST_QUIET: assert property (disable iff (1'b0)
		!rstn |=> in_ready == '0 && in_reject == '0 && out_valid == '0)
		else $error("outputs active in reset");
	AST_READY_UP: assert property (rstn && !$past(rstn) |=> &in_ready)
		else $error("entries not ready after reset");
	AST_TIE_LOW: assert property (p_one_loses(0, 1))
		else $error("tie on low pair not settled");
	AST_TIE_HIGH: assert property (p_one_loses(2, 3))
		else $error("tie on high pair not settled");
	for (genvar i = 0; i < PORTS; i++) begin : g_port
		AST_REJ_CAUSE: assert property (in_reject[i] |-> $past(take[i]) || $past(|out_reject))
			else $error("reject without cause");
		AST_BODY_KEPT: assert property (take[i] && busy_q[i] && !(|out_reject) |=> !in_reject[i])
			else $error("body nibble rejected");
		AST_OUT_HOLD: assert property (out_valid[i] && !out_ready[i] && !out_reject[i]
			&& !$past(out_reject[i]) |=> out_valid[i] && $stable(out_data[NIB_W*i+:NIB_W])
			&& $stable(out_last[i])) else $error("exit data not held");
		AST_OUT_FROM_LEFT: assert property ($rose(out_valid[i]) |->
			$past(take[2*(i%2)] || take[2*(i%2)+1], 1) || $past(take[2*(i%2)] || take[2*(i%2)+1], 2)
			|| $past(take[2*(i%2)] || take[2*(i%2)+1], 3)) else $error("exit fed without entry");
	end
endmodule : sdsn_node_monitor

bind sdsn_node sdsn_node_monitor #(.PORTS(PORTS), .NIB_W(NIB_W), .FIFO_DEPTH(FIFO_DEPTH))
	sdsn_node_monitor_inst (.sys_clk(sys_clk), .rstn(rstn), .in_valid(in_valid),
	.in_last(in_last), .in_data(in_data), .in_ready(in_ready), .in_reject(in_reject),
	.out_valid(out_valid), .out_last(out_last), .out_data(out_data),
	.out_ready(out_ready), .out_reject(out_reject));

// ===== tb/sdsn_sink_model.sv
`timescale 1ns/10ps
// ==========================================================================
// Downstream stage: takes nibbles and may order a retreat
module sdsn_sink_model
	import sdsn_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	// Control from the bench
	input  wire logic [3:0] stall,
	input  wire logic       slow,
	input  wire logic [3:0] rej_cmd,
	// Exit side of the node
	output logic      [3:0] out_ready,
	output logic      [3:0] out_reject
);
	// Endpoint duties beyond this stage are met by resending sources
	// Random ready in slow mode so the exit buffers really fill and drain
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) out_ready <= '0;
		else out_ready <= ~stall & (slow ? 4'($urandom) : 4'hf);
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) out_reject <= '0;
		else out_reject <= rej_cmd;
	end
endmodule : sdsn_sink_model

// ===== tb/sdsn_node_tb.sv
`timescale 1ns/10ps
module sdsn_node_tb
	import sdsn_pkg::*;
();
	logic        sys_clk  = 1'b0;
	logic        rstn     = 1'b0;
	logic        slow     = 1'b0;
	logic [3:0]  in_valid = '0, in_last = '0, stall = '0, rej_cmd = '0;
	logic [15:0] in_data  = '0;
	logic [3:0]  in_ready, in_reject, out_valid, out_last, out_ready, out_reject;
	logic [15:0] out_data;
	logic [4:0]  src_q[4][$], got_q[4][$], exp_q[4][$];
	int          rej_n[4], snap[4];
	int          err_count, comparisons;

	always #2 sys_clk = ~sys_clk;

	sdsn_node sdsn_node_inst (.sys_clk(sys_clk), .rstn(rstn), .in_valid(in_valid),
		.in_last(in_last), .in_data(in_data), .in_ready(in_ready), .in_reject(in_reject),
		.out_valid(out_valid), .out_last(out_last), .out_data(out_data),
		.out_ready(out_ready), .out_reject(out_reject));
	sdsn_sink_model sdsn_sink_model_inst (.sys_clk(sys_clk), .rstn(rstn), .stall(stall),
		.slow(slow), .rej_cmd(rej_cmd), .out_ready(out_ready), .out_reject(out_reject));

	// ======================================================================
	// Sources, capture and expectation
	always @(posedge sys_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (in_valid[i] === 1'b1 && in_ready[i] === 1'b1) void'(src_q[i].pop_front());
			if (in_reject[i] === 1'b1) rej_n[i]++;
			if (out_valid[i] === 1'b1 && out_ready[i] === 1'b1)
				got_q[i].push_back({out_last[i], out_data[4*i+:4]});
			in_valid[i] <= src_q[i].size() > 0;
			{in_last[i], in_data[4*i+:4]} <= src_q[i].size() ? src_q[i][0] : 5'h00;
		end
	end

	function automatic int ex(int i, logic [3:0] h);
		return h[0] * 2 + i / 2;
	endfunction : ex
	function automatic logic [3:0] rot(logic [3:0] h);
		return {h[0], h[3:1]};
	endfunction : rot

	task automatic chk(bit ok, string m);
		comparisons++;
		if (!ok) begin
			err_count++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task automatic send(int i, int n, logic [3:0] h);
		for (int k = 0; k < n; k++) begin
			logic [3:0] d;
			d = k ? 4'($urandom) : h;
			src_q[i].push_back({k == n - 1, d});
			exp_q[ex(i, h)].push_back({k == n - 1, k ? d : rot(h)});
		end
	endtask : send
	task automatic drain();
		int k;
		int q;
		k = 0;
		q = 0;
		while (k < 3000 && q < 8) begin
			@(negedge sys_clk);
			k++;
			q = (src_q[0].size() + src_q[1].size() + src_q[2].size() + src_q[3].size() > 0
				|| out_valid !== 4'h0) ? 0 : q + 1;
		end
		chk(k < 3000, "drain timeout");
	endtask : drain
	task automatic cmp();
		for (int e = 0; e < 4; e++) begin
			chk(got_q[e].size() == exp_q[e].size(), "nibble count");
			for (int k = 0; k < exp_q[e].size() && k < got_q[e].size(); k++)
				chk(got_q[e][k] === exp_q[e][k], "nibble value");
			got_q[e].delete();
			exp_q[e].delete();
		end
	endtask : cmp
	task automatic pulse(int e);
		@(posedge sys_clk) rej_cmd <= 4'(1 << e);
		@(posedge sys_clk) rej_cmd <= 4'h0;
	endtask : pulse
	task automatic stop_test();
		if (err_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stop_test

	// Whole run is about a thousand cycles; allow twenty times that
	initial begin
		#(20000 * 4);
		err_count++;
		stop_test();
	end

	// ======================================================================
	// Main sequence
	initial begin
		int a;
		int r;
		int e;
		logic [3:0] h;
		void'($urandom(32'hf4a43d7e));
		repeat (4) @(negedge sys_clk);
		chk(in_ready === 4'h0 && out_valid === 4'h0 && in_reject === 4'h0, "reset");
		@(posedge sys_clk) rstn <= 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(in_ready === 4'hf, "ready after reset");
		// Ties: upper entry wins first on every exit, then priority rotates
		for (r = 0; r < 2; r++) for (a = 0; a < 4; a += 2) for (e = 0; e < 2; e++) begin
			h = {3'($urandom), e[0]};
			snap = rej_n;
			src_q[a].push_back({1'b1, h});
			src_q[a+1].push_back({1'b1, h});
			exp_q[ex(a, h)].push_back({1'b1, rot(h)});
			drain();
			chk(rej_n[a+r] - snap[a+r] == 1 && rej_n[a+1-r] == snap[a+1-r], "tie");
		end
		cmp();
		@(posedge sys_clk) slow <= 1'b1;
		for (r = 0; r < 20; r++) begin
			if (r % 2) for (a = 0; a < 4; a++) send(a, 1 + $urandom % 6, {3'($urandom), a[0]});
			else for (a = 0; a < 4; a += 2) for (e = 0; e < 2; e++)
				send(a, 1 + $urandom % 6, {3'($urandom), e[0]});
			drain();
		end
		cmp();
		// Stalled exit fills its buffer and refuses a second owner
		@(posedge sys_clk) stall <= 4'h1;
		send(0, 24, {3'($urandom), 1'b0});
		repeat (60) @(negedge sys_clk);
		chk(in_ready[0] === 1'b0 && 24 - src_q[0].size() <= SDSN_FIFO_DEPTH
			&& 24 - src_q[0].size() >= SDSN_FIFO_DEPTH - 2 * SDSN_READY_MARGIN, "fill");
		snap = rej_n;
		src_q[1].push_back({1'b1, 4'h2});
		repeat (4) @(negedge sys_clk);
		chk(rej_n[1] - snap[1] == 1, "busy exit");
		@(posedge sys_clk) stall <= 4'h0;
		drain();
		cmp();
		// Retreat honoured before the tail, ignored after it
		@(posedge sys_clk) stall <= 4'h4;
		snap = rej_n;
		src_q[1].push_back({1'b0, 4'h3});
		repeat (6) @(negedge sys_clk);
		pulse(2);
		repeat (3) @(negedge sys_clk);
		chk(rej_n[1] - snap[1] == 1 && out_valid[2] === 1'b0, "early retreat");
		send(0, 3, 4'h5);
		repeat (10) @(negedge sys_clk);
		snap = rej_n;
		pulse(2);
		repeat (3) @(negedge sys_clk);
		chk(rej_n[0] == snap[0], "late retreat");
		@(posedge sys_clk) stall <= 4'h0;
		drain();
		cmp();
		stop_test();
	end
endmodule : sdsn_node_tb
